// >>> verilog/cpm_map.svh
// Timing counts and encodings for the charge port fault and load monitor.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH
`define CPM_CLK_HZ         10000000
`define CPM_OC_DEG_MS      8
`define CPM_OV_DEG_MS      16
`define CPM_LD_SET_MS      210
`define CPM_LD_RST_MS      3000
`define CPM_QUICK_CLR_MS   1
`define CPM_MS_CYC         (`CPM_CLK_HZ / 1000)
`define CPM_DCHG_MS        320
`define CPM_MODE_CHARGE    2'h0
`define CPM_MODE_DATA_LP   2'h1
`define CPM_MODE_CHARGE_LP 2'h2
`define CPM_MODE_DATA      2'h3
`endif

// >>> verilog/cpm_pkg.sv
// Types shared by the charge port monitor files.
// Assumes cpm_map.svh is available for numeric constants.
package cpm_pkg;
  // Sense inputs from the analog comparators, all synchronous to the clock.
  typedef struct packed {
    logic over_limit;      // Output current above active limit.
    logic temp_limited;    // Junction above lower thermal trip.
    logic temp_unlimited;  // Junction above higher thermal trip.
    logic temp_cooled;     // Junction has fallen by the hysteresis.
    logic data_plus_line;  // Data plus above overvoltage threshold.
    logic data_minus_line; // Data minus above overvoltage threshold.
    logic load_above;      // Load above lower limit plus margin.
    logic load_below;      // Load below lower limit minus margin.
  } cpm_sense_type;
  // Switch and discharge controls towards the analog section.
  typedef struct packed {
    logic power_on;        // Internal power switch closed.
    logic data_on;         // USB data switches closed.
    logic out_discharge;   // Output discharge path enabled.
    logic line_discharge;  // Data line discharge path enabled.
    logic use_upper_limit; // Upper current limit selected.
    logic advertise;       // Advertise high-current charging.
  } cpm_ctrl_type;
  typedef enum logic [1:0] {
    CPM_IDLE,
    CPM_DISCHARGE,
    CPM_RESTORE
  } cpm_dchg_type;
endpackage

// >>> verilog/cpm_deglitch.sv
// Qualifying timer: the output follows the input after it stays stable.
// Assumes a one-cycle millisecond tick and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module cpm_deglitch #(
  parameter int  WIDTH   = 16,
  parameter logic [15:0] SET_MS = 16'h0008,
  parameter logic [15:0] CLR_MS = 16'h0008,
  parameter bit  CLR_NOW = 1'b0
) (
  input  wire logic core_clk, // Core clock.
  input  wire logic reset_n,  // Synchronous reset, active low.
  input  wire logic ms_tick,  // One-cycle millisecond pulse.
  input  wire logic level_in, // Raw condition.
  output var  logic qual_out  // Qualified condition.
);
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic             qual_nxt;
  wire logic        differs = level_in != qual_out;
  wire logic [WIDTH-1:0] limit = qual_out ? WIDTH'(CLR_MS) : WIDTH'(SET_MS);
  wire logic        done    = ms_tick && (cnt_r + WIDTH'(1) >= limit);

  // A return to agreement clears the count, so only a stable level qualifies.
  always_comb begin
    cnt_nxt  = '0;
    qual_nxt = qual_out;
    if (differs && qual_out && CLR_NOW) begin
      qual_nxt = 1'b0;
    end else if (differs && done) begin
      qual_nxt = level_in;
    end else if (differs) begin
      cnt_nxt = ms_tick ? cnt_r + WIDTH'(1) : cnt_r;
    end
  end

  // Reset clears the timer and the qualified state.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_r    <= '0;
      qual_out <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      qual_out <= qual_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/cpm_monitor.sv
// Supervisory logic of a charging-port power switch: fault qualification,
// switch sequencing and the load-detect status timing.
// Assumes synchronous sense inputs from analog comparators and a 10 MHz clock.
`include "cpm_map.svh"
`timescale 1ns/100ps
`default_nettype none
module cpm_monitor #(
  parameter int unsigned MS_CYC   = `CPM_MS_CYC,
  parameter int unsigned DCHG_MS  = `CPM_DCHG_MS
) (
  input  wire logic                   core_clk,      // Core clock, 10 MHz.
  input  wire logic                   reset_n,       // Synchronous reset, active low.
  input  wire logic [1:0]             port_mode,     // Port mode select.
  input  wire logic                   renegotiate,   // Pulse: run output discharge.
  input  wire cpm_pkg::cpm_sense_type sense,         // Comparator levels.
  output var  cpm_pkg::cpm_ctrl_type  ctrl,          // Switch controls.
  output logic                        fault_o,       // Fault pin output value.
  output logic                        fault_oe,      // Fault pin drives low when high.
  output logic                        status_o,      // Status pin output value.
  output logic                        status_oe,     // Status pin drives low when high.
  output var  logic                   thermal_off    // Thermal shutdown active.
);
  // Timebase, thermal latch, discharge sequencer and load status state.
  logic [23:0]          div_r;
  logic                 ms_tick_r;
  logic                 therm_r;
  logic [15:0]          dchg_cnt_r;
  cpm_pkg::cpm_dchg_type dchg_r;
  logic                 load_r;

  // Qualified levels from the four timers.
  logic                 oc_q;
  logic                 ov_q;
  logic                 ld_set_q;
  logic                 ld_clr_q;

  // Mode decode; a port is charging only in the charge mode, not in the data or low-power modes.
  // The plain data mode charges at the lower limit yet still reports an
  // overcurrent, since only the two low-power modes mask it.
  wire logic lp_mode   = (port_mode == `CPM_MODE_DATA_LP) ||
                         (port_mode == `CPM_MODE_CHARGE_LP);
  wire logic charging  = (port_mode == `CPM_MODE_CHARGE);
  // Load timers only run in a charging port, so a demoted port starts over.
  wire logic ld_high   = sense.load_above && charging;
  wire logic ld_low    = sense.load_below && charging;
  wire logic line_ov   = sense.data_plus_line || sense.data_minus_line;
  wire logic oc_raw    = sense.over_limit && !lp_mode;
  wire logic trip      = sense.over_limit ? sense.temp_limited
                                          : sense.temp_unlimited;
  wire logic fault_any = therm_r || oc_q || ov_q;
  wire logic div_end   = div_r == 24'(MS_CYC - 1);

  // Millisecond enable from the core clock divider.
  // The tick phase runs free against the sense inputs, so every qualifying
  // interval is uncertain by up to one tick; the counts aim at the top end.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      div_r     <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      div_r     <= div_end ? '0 : div_r + 24'h000001;
      ms_tick_r <= div_end;
    end
  end

  // Current fault: same deglitch both ways, so a load that hovers at the
  // limit cannot make the pin chatter.
  cpm_deglitch #(
    .WIDTH   (16),
    .SET_MS  (16'(`CPM_OC_DEG_MS)),
    .CLR_MS  (16'(`CPM_OC_DEG_MS)),
    .CLR_NOW (1'b0)
  ) u_oc (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .ms_tick  (ms_tick_r),
    .level_in (oc_raw),
    .qual_out (oc_q)
  );

  // Line fault: qualified on set, released as soon as the line recovers.
  // The data switch itself does not wait for this timer.
  cpm_deglitch #(
    .WIDTH   (16),
    .SET_MS  (16'(`CPM_OV_DEG_MS)),
    .CLR_MS  (16'(`CPM_QUICK_CLR_MS)),
    .CLR_NOW (1'b1)
  ) u_ov (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .ms_tick  (ms_tick_r),
    .level_in (line_ov),
    .qual_out (ov_q)
  );

  // Load detect timers; only meaningful while charging.
  cpm_deglitch #(
    .WIDTH   (16),
    .SET_MS  (16'(`CPM_LD_SET_MS)),
    .CLR_MS  (16'(`CPM_QUICK_CLR_MS)),
    .CLR_NOW (1'b1)
  ) u_ld_set (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .ms_tick  (ms_tick_r),
    .level_in (ld_high),
    .qual_out (ld_set_q)
  );

  // Light-load timer; a single heavier sample restarts the long count.
  cpm_deglitch #(
    .WIDTH   (16),
    .SET_MS  (16'(`CPM_LD_RST_MS)),
    .CLR_MS  (16'(`CPM_QUICK_CLR_MS)),
    .CLR_NOW (1'b1)
  ) u_ld_clr (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .ms_tick  (ms_tick_r),
    .level_in (ld_low),
    .qual_out (ld_clr_q)
  );

  // Thermal latch: trips at once, holds until the die has cooled.
  // A trip wins over a cooled reading in the same cycle, so a die that is
  // still hot never restarts; the off and on cycling repeats on its own.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      therm_r <= 1'b0;
    end else if (trip) begin
      therm_r <= 1'b1;
    end else if (sense.temp_cooled) begin
      therm_r <= 1'b0;
    end
  end

  // Status holds between set and clear; a non-charging port reports none.
  // The pin comes from a register, so the controller never sees a glitch
  // while the two load timers hand over to each other.
  always_ff @(posedge core_clk) begin
    if (!reset_n || !charging) begin
      load_r <= 1'b0;
    end else if (ld_set_q) begin
      load_r <= 1'b1;
    end else if (ld_clr_q) begin
      load_r <= 1'b0;
    end
  end

  // Output discharge sequence; a new request during it is ignored.
  // The length counts whole ticks, so the off time may fall short of the
  // nominal value by up to one tick.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      dchg_r     <= cpm_pkg::CPM_IDLE;
      dchg_cnt_r <= '0;
    end else begin
      case (dchg_r)
        cpm_pkg::CPM_IDLE: begin
          dchg_cnt_r <= '0;
          if (renegotiate) begin
            dchg_r <= cpm_pkg::CPM_DISCHARGE;
          end
        end
        cpm_pkg::CPM_DISCHARGE: begin
          if (ms_tick_r) begin
            dchg_cnt_r <= dchg_cnt_r + 16'h0001;
          end
          if (ms_tick_r && dchg_cnt_r == 16'(DCHG_MS - 1)) begin
            dchg_r <= cpm_pkg::CPM_RESTORE;
          end
        end
        cpm_pkg::CPM_RESTORE: begin
          dchg_r <= cpm_pkg::CPM_IDLE;
        end
        default: begin
          dchg_r <= cpm_pkg::CPM_IDLE;
        end
      endcase
    end
  end

  // Switch controls; the overvoltage path is raw so the data switch opens
  // without waiting for any deglitch.
  // A thermal shutdown opens both switches regardless of the sequencer, and
  // the line recovers by itself once the raw overvoltage has gone.
  assign ctrl.power_on        = !therm_r && (dchg_r != cpm_pkg::CPM_DISCHARGE);
  assign ctrl.data_on         = !therm_r && !line_ov;
  assign ctrl.out_discharge   = dchg_r == cpm_pkg::CPM_DISCHARGE;
  assign ctrl.line_discharge  = line_ov;
  assign ctrl.use_upper_limit = charging;
  assign ctrl.advertise       = charging;
  assign thermal_off          = therm_r;

  // Open-drain pins only ever pull low.
  // The value outputs stay tied low; the pad turns the enable into the
  // pull-down, and the external pull-up gives the released level.
  // Both enables come straight from registers or a gate of registers.
  assign fault_o   = 1'b0;
  assign fault_oe  = fault_any;
  assign status_o  = 1'b0;
  assign status_oe = load_r;
endmodule
`default_nettype wire

// >>> dv/cpm_monitor_sva.sv
// Assertions on the charge port monitor ports.
// Bound into every cpm_monitor; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module cpm_monitor_sva #(
  parameter int unsigned MS_CYC  = 10,
  parameter int unsigned DCHG_MS = 2
) (
  input wire logic                   core_clk,    // Clock.
  input wire logic                   reset_n,     // Reset, low.
  input wire logic [1:0]             port_mode,   // Mode.
  input wire logic                   renegotiate, // Discharge pulse.
  input wire cpm_pkg::cpm_sense_type sense,       // Comparators.
  input wire cpm_pkg::cpm_ctrl_type  ctrl,        // Controls.
  input wire logic                   fault_o,     // Fault value.
  input wire logic                   fault_oe,    // Fault drive.
  input wire logic                   status_o,    // Status value.
  input wire logic                   status_oe,   // Status drive.
  input wire logic                   thermal_off  // Shutdown.
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  int unsigned oc_run_r;
  int unsigned ld_run_r;
  // Raw run lengths; the bounds sit two ticks below each nominal deglitch count.
  always_ff @(posedge core_clk) begin
    oc_run_r <= (reset_n && sense.over_limit) ? oc_run_r + 1 : 0;
    ld_run_r <= (reset_n && sense.load_above) ? ld_run_r + 1 : 0;
  end
  a_pins_low: assert property (fault_o == 1'b0 && status_o == 1'b0)
    else $error("pin value not low");
  a_oc_deglitch: assert property ($rose(fault_oe) && !thermal_off
    && !sense.data_plus_line && !sense.data_minus_line |-> oc_run_r >= 6 * MS_CYC)
    else $error("current fault too early");
  a_line_open: assert property (sense.data_plus_line || sense.data_minus_line
    |-> !ctrl.data_on && ctrl.line_discharge)
    else $error("data switch closed in overvoltage");
  a_thermal_open: assert property (thermal_off |-> !ctrl.power_on && !ctrl.data_on)
    else $error("switch closed in shutdown");
  a_thermal_fault: assert property (thermal_off |-> fault_oe)
    else $error("shutdown not reported");
  a_discharge_off: assert property (ctrl.out_discharge |-> !ctrl.power_on)
    else $error("power on while discharging");
  a_status_qual: assert property ($rose(status_oe) |-> ld_run_r >= 208 * MS_CYC)
    else $error("status set too early");
  a_limit_select: assert property (port_mode == $past(port_mode)
    |-> ctrl.use_upper_limit == (port_mode == 2'h0))
    else $error("wrong current limit");
endmodule
bind cpm_monitor cpm_monitor_sva #(.MS_CYC(MS_CYC), .DCHG_MS(DCHG_MS)) u_sva (
  .core_clk(core_clk), .reset_n(reset_n), .port_mode(port_mode),
  .renegotiate(renegotiate), .sense(sense), .ctrl(ctrl), .fault_o(fault_o),
  .fault_oe(fault_oe), .status_o(status_o), .status_oe(status_oe),
  .thermal_off(thermal_off));
`default_nettype wire

// >>> dv/cpm_share_model.sv
// System controller sharing one high-load slot between this port and a peer.
// Assumes the peer's load status arrives as a plain level.
`include "cpm_map.svh"
`timescale 1ns/100ps
`default_nettype none
module cpm_share_model (
  input  wire logic       status_oe,   // Own load status.
  input  wire logic       peer_status, // Peer load status.
  input  wire logic       share_en,    // Sharing active.
  input  wire logic [1:0] want_mode,   // Mode when not demoted.
  output logic [1:0]      port_mode    // Mode to the port.
);
  // Demotion and restore are instant; a slower controller only widens the gaps.
  assign port_mode = (share_en && peer_status && !status_oe) ? `CPM_MODE_DATA : want_mode;
endmodule
`default_nettype wire

// >>> dv/charge_port_fault_load_monitor_tb.sv
// Self-checking bench for the charge port monitor with its sharing controller.
// Assumes the monitor, checker and sharing model are compiled first.
`include "cpm_map.svh"
`timescale 1ns/100ps
`default_nettype none
module charge_port_fault_load_monitor_tb;
  localparam int MS = 10;
  logic core_clk = 1'b0, reset_n = 1'b0, renegotiate = 1'b0;
  logic peer_status = 1'b0, share_en = 1'b0;
  logic [1:0] want_mode = 2'h0, port_mode;
  cpm_pkg::cpm_sense_type sense = '0;
  cpm_pkg::cpm_ctrl_type ctrl;
  logic fault_o, fault_oe, status_o, status_oe, thermal_off;
  int fails = 0, checked = 0, cycles = 0, n;
  always #50 core_clk = ~core_clk;
  cpm_monitor #(.MS_CYC(MS), .DCHG_MS(2)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .port_mode(port_mode), .renegotiate(renegotiate), .sense(sense), .ctrl(ctrl),
    .fault_o(fault_o), .fault_oe(fault_oe), .status_o(status_o), .status_oe(status_oe),
    .thermal_off(thermal_off));
  cpm_share_model peer (.status_oe(status_oe), .peer_status(peer_status),
    .share_en(share_en), .want_mode(want_mode), .port_mode(port_mode));
  task automatic ck(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  // Only a port in the charging mode takes the upper limit and advertises it.
  function automatic logic exp_upper(input logic [1:0] mode);
    return mode == `CPM_MODE_CHARGE;
  endfunction
  task automatic wait_ms(input int ms);
    repeat (ms * MS) @(negedge core_clk);
  endtask
  task automatic end_of_test;
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // A hang counts as a mismatch; the full run needs about 33200 cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    n = $urandom(32'h2ba0);
    repeat (5) @(negedge core_clk);
    reset_n = 1'b1;
    ck(fault_oe | status_oe, 1'b0, "outputs after reset");
    ck(fault_o | status_o, 1'b0, "pin value high");
    // A random glitch shorter than the deglitch, then a real overload.
    sense.over_limit = 1'b1;
    wait_ms(1 + $urandom % 6);
    sense.over_limit = 1'b0;
    wait_ms(9);
    ck(fault_oe, 1'b0, "glitch reported");
    sense.over_limit = 1'b1;
    wait_ms(9);
    ck(fault_oe, 1'b1, "overload missed");
    sense.over_limit = 1'b0;
    wait_ms(6);
    ck(fault_oe, 1'b1, "early release");
    wait_ms(3);
    ck(fault_oe, 1'b0, "no release");
    for (int m = 1; m < 3; m++) begin
      want_mode = 2'(m);
      sense.over_limit = 1'b1;
      wait_ms(9);
      ck(fault_oe, 1'b0, "low-power overload reported");
      sense.over_limit = 1'b0;
      wait_ms(9);
    end
    // Random modes: the limit and the advertisement follow the mode at once.
    repeat (8) begin
      want_mode = 2'($urandom);
      @(negedge core_clk);
      ck(ctrl.use_upper_limit, exp_upper(want_mode), "limit select");
      ck(ctrl.advertise, exp_upper(want_mode), "advertise select");
    end
    want_mode = 2'h0;
    for (int k = 0; k < 2; k++) begin
      sense.data_plus_line = (k == 0);
      sense.data_minus_line = (k == 1);
      #1;
      ck(ctrl.data_on, 1'b0, "data switch closed");
      ck(ctrl.line_discharge, 1'b1, "no line discharge");
      wait_ms(14);
      ck(fault_oe, 1'b0, "line fault early");
      wait_ms(3);
      ck(fault_oe, 1'b1, "line fault missed");
      sense.data_plus_line = 1'b0;
      sense.data_minus_line = 1'b0;
      repeat (2) @(negedge core_clk);
      ck(fault_oe, 1'b0, "line fault held");
      ck(ctrl.data_on & !ctrl.line_discharge, 1'b1, "no line recovery");
    end
    // The lower trip counts only while limiting.
    sense.temp_limited = 1'b1;
    repeat (3) @(negedge core_clk);
    ck(thermal_off, 1'b0, "lower trip unlimited");
    sense.over_limit = 1'b1;
    repeat (2) @(negedge core_clk);
    ck(thermal_off & fault_oe, 1'b1, "lower trip missed");
    ck(ctrl.power_on, 1'b0, "power on in trip");
    sense = '0;
    sense.temp_cooled = 1'b1;
    repeat (2) @(negedge core_clk);
    ck(ctrl.power_on & !thermal_off, 1'b1, "no restart");
    sense = '0;
    sense.temp_unlimited = 1'b1;
    repeat (2) @(negedge core_clk);
    ck(thermal_off, 1'b1, "upper trip missed");
    sense = '0;
    sense.temp_cooled = 1'b1;
    repeat (2) @(negedge core_clk);
    sense = '0;
    renegotiate = 1'b1;
    @(negedge core_clk);
    renegotiate = 1'b0;
    @(negedge core_clk);
    ck(ctrl.out_discharge & !ctrl.power_on, 1'b1, "no discharge");
    // A reset in mid-sequence abandons the discharge and recloses the switch.
    reset_n = 1'b0;
    @(negedge core_clk);
    reset_n = 1'b1;
    ck(ctrl.power_on & !ctrl.out_discharge & !thermal_off, 1'b1, "reset kept discharge");
    wait_ms(4);
    ck(ctrl.power_on & !ctrl.out_discharge, 1'b1, "no reclose");
    sense.load_above = 1'b1;
    wait_ms(208);
    ck(status_oe, 1'b0, "status early");
    wait_ms(4);
    ck(status_oe, 1'b1, "status missed");
    peer_status = 1'b1;
    share_en = 1'b1;
    sense.load_above = 1'b0;
    sense.load_below = 1'b1;
    wait_ms(2997);
    ck(ctrl.use_upper_limit & status_oe, 1'b1, "status dropped early");
    wait_ms(4);
    ck(status_oe | ctrl.use_upper_limit, 1'b0, "not demoted");
    peer_status = 1'b0;
    @(negedge core_clk);
    ck(ctrl.use_upper_limit & ctrl.advertise, 1'b1, "not restored");
    end_of_test();
  end
endmodule
`default_nettype wire
